// [include/sflsc_pkg.sv]
// package of constants for the serial flash link state controller
package sflsc_pkg;
  // one-hot link states
  typedef enum logic [3:0] {
    SFLSC_ST_INIT = 4'h1,
    SFLSC_ST_DETACHED = 4'h2,
    SFLSC_ST_SLOW = 4'h4,
    SFLSC_ST_FULL = 4'h8
  } sflsc_state_e;
  // command codes
  localparam logic [2:0] SFLSC_CMD_NONE = 3'h0;
  localparam logic [2:0] SFLSC_CMD_GO_FAST = 3'h1;
  localparam logic [2:0] SFLSC_CMD_DISCONNECT = 3'h2;
  localparam logic [2:0] SFLSC_CMD_RECONNECT = 3'h3;
  localparam logic [2:0] SFLSC_CMD_RAW_DESELECT = 3'h4;
  localparam logic [2:0] SFLSC_CMD_RAW_TRANSMIT = 3'h5;
  localparam logic [2:0] SFLSC_CMD_RAW_RECEIVE = 3'h6;
  // probe / fetch command bytes and probe id values on the wire
  localparam logic [7:0] SFLSC_OP_READ_ID = 8'h9F;
  localparam logic [7:0] SFLSC_OP_QUAD_READ = 8'hEB;
  localparam logic [7:0] SFLSC_ID_ABSENT = 8'hFF;
  localparam logic [7:0] SFLSC_ID_ZERO = 8'h00;
  // image signature byte at the image base
  localparam logic [7:0] SFLSC_IMG_SIGN = 8'hA5;
  localparam logic [23:0] SFLSC_IMG_ADDR = 24'h000000;
  // image length in bytes, for reference of the host flow
  localparam int SFLSC_IMG_BYTES = 4096;
  // shift engine geometry
  localparam logic [3:0] SFLSC_BITS_SINGLE = 4'h8;
  localparam logic [3:0] SFLSC_BITS_QUAD = 4'h2;
  localparam logic [3:0] SFLSC_CNT_ONE = 4'h1;
  localparam logic [3:0] SFLSC_CNT_ZERO = 4'h0;
  localparam logic [2:0] SFLSC_ADDR_BYTES = 3'h3;
  localparam logic [2:0] SFLSC_DUMMY_BYTES = 3'h3;
endpackage

// [design/sflsc_shifter.sv]
// byte shift engine for single and quad line serial transfers
`timescale 1ns/1ns
module sflsc_shifter
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic abort_i,
  input wire logic start_i,
  input wire logic quad_i,
  input wire logic rx_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic [3:0] io_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rx_byte_o,
  output logic sclk_o,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o
);
  // ==========================================================
  // shift state
  logic [7:0] sh_reg, sh_next;
  logic [3:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;
  logic quad_reg, quad_next;
  logic rx_reg, rx_next;
  logic done_reg, done_next;
  logic [7:0] rxb_reg, rxb_next;

  always_comb
  begin
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    quad_next = quad_reg;
    rx_next = rx_reg;
    done_next = 1'b0;
    rxb_next = rxb_reg;
    if (abort_i)
      busy_next = 1'b0;
    else if (!busy_reg && start_i)
    begin
      sh_next = tx_byte_i;
      busy_next = 1'b1;
      quad_next = quad_i;
      rx_next = rx_i;
      cnt_next = quad_i ? sflsc_pkg::SFLSC_BITS_QUAD
                        : sflsc_pkg::SFLSC_BITS_SINGLE;
    end
    else if (busy_reg)
    begin
      // one bit or nibble per clock; serial clock is inverted mclk while busy
      if (quad_reg)
        sh_next = {sh_reg[3:0], io_i};
      else
        sh_next = {sh_reg[6:0], io_i[1]};
      cnt_next = cnt_reg - sflsc_pkg::SFLSC_CNT_ONE;
      if (cnt_reg == sflsc_pkg::SFLSC_CNT_ONE)
      begin
        busy_next = 1'b0;
        done_next = 1'b1;
        rxb_next = quad_reg ? {sh_reg[3:0], io_i}
                            : {sh_reg[6:0], io_i[1]};
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
      busy_reg <= 1'b0;
      quad_reg <= 1'b0;
      rx_reg <= 1'b0;
      done_reg <= 1'b0;
      rxb_reg <= 8'h00;
    end
    else
    begin
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      quad_reg <= quad_next;
      rx_reg <= rx_next;
      done_reg <= done_next;
      rxb_reg <= rxb_next;
    end
  end

  // ==========================================================
  // pin drive
  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign rx_byte_o = rxb_reg;
  assign sclk_o = busy_reg & ~mclk_i;
  always_comb
  begin
    io_o = 4'h0;
    io_oe_o = 4'h0;
    if (busy_reg && !rx_reg)
    begin
      if (quad_reg)
      begin
        io_o = sh_reg[7:4];
        io_oe_o = 4'hF;
      end
      else
      begin
        io_o = {3'h0, sh_reg[7]};
        io_oe_o = 4'h1;
      end
    end
  end
endmodule

// [design/sflsc_link_ctrl.sv]
// flash link state controller with probe, raw bus and quad fetch paths
`timescale 1ns/1ns
module sflsc_link_ctrl
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] cmd_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] raw_tx_byte_i,
  output logic cmd_done_o,
  output logic [7:0] raw_rx_byte_o,
  output logic [3:0] link_state_o,
  output logic fast_failed_o,
  input wire logic fetch_req_i,
  input wire logic [23:0] fetch_addr_i,
  output logic fetch_ready_o,
  output logic fetch_valid_o,
  output logic [7:0] fetch_data_o,
  output logic flash_sclk_o,
  output logic flash_cs_n_o,
  output logic [3:0] flash_io_o,
  output logic [3:0] flash_io_oe_o,
  input wire logic [3:0] flash_io_i
);
  typedef enum logic [6:0] {
    SFLSC_SEQ_IDLE = 7'h01,
    SFLSC_SEQ_OP = 7'h02,
    SFLSC_SEQ_ADDR = 7'h04,
    SFLSC_SEQ_DUMMY = 7'h08,
    SFLSC_SEQ_DATA = 7'h10,
    SFLSC_SEQ_RAW = 7'h20,
    SFLSC_SEQ_END = 7'h40
  } sflsc_seq_e;
  typedef enum logic [2:0] {
    SFLSC_JOB_PROBE = 3'h1,
    SFLSC_JOB_CHECK = 3'h2,
    SFLSC_JOB_FETCH = 3'h4
  } sflsc_job_e;

  // ==========================================================
  // control state
  sflsc_pkg::sflsc_state_e st_reg, st_next;
  sflsc_seq_e seq_reg, seq_next;
  sflsc_job_e job_reg, job_next;
  logic [23:0] addr_reg, addr_next;
  logic [2:0] bcnt_reg, bcnt_next;
  logic cs_n_reg, cs_n_next;
  logic done_reg, done_next;
  logic fail_reg, fail_next;
  logic fval_reg, fval_next;
  logic [7:0] fdat_reg, fdat_next;
  logic [7:0] rawrx_reg, rawrx_next;
  logic boot_reg, boot_next;
  logic sh_start, sh_quad, sh_rx, sh_busy, sh_done, sh_abort;
  logic [7:0] sh_tx, sh_rxb;
  logic sh_sclk;
  logic [3:0] sh_io, sh_oe;
  sflsc_shifter u_shift
  (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .abort_i(sh_abort),
    .start_i(sh_start),
    .quad_i(sh_quad),
    .rx_i(sh_rx),
    .tx_byte_i(sh_tx),
    .io_i(flash_io_i),
    .busy_o(sh_busy),
    .done_o(sh_done),
    .rx_byte_o(sh_rxb),
    .sclk_o(sh_sclk),
    .io_o(sh_io),
    .io_oe_o(sh_oe)
  );
  logic attached;
  assign attached = (st_reg == sflsc_pkg::SFLSC_ST_SLOW)
                    || (st_reg == sflsc_pkg::SFLSC_ST_FULL);

  // ==========================================================
  // state and sequence
  always_comb
  begin
    st_next = st_reg;
    seq_next = seq_reg;
    job_next = job_reg;
    addr_next = addr_reg;
    bcnt_next = bcnt_reg;
    cs_n_next = cs_n_reg;
    done_next = 1'b0;
    fail_next = fail_reg;
    fval_next = 1'b0;
    fdat_next = fdat_reg;
    rawrx_next = rawrx_reg;
    boot_next = 1'b0;
    sh_start = 1'b0;
    sh_quad = 1'b0;
    sh_rx = 1'b0;
    sh_tx = 8'h00;
    sh_abort = 1'b0;
    if (cmd_valid_i && cmd_i == sflsc_pkg::SFLSC_CMD_DISCONNECT)
    begin
      st_next = sflsc_pkg::SFLSC_ST_DETACHED;
      sh_abort = 1'b1;
      seq_next = SFLSC_SEQ_IDLE;
      cs_n_next = 1'b1;
      done_next = 1'b1;
    end
    else
    begin
      unique case (seq_reg)
        SFLSC_SEQ_IDLE:
        begin
          if (boot_reg)
          begin
            job_next = SFLSC_JOB_PROBE;
            seq_next = SFLSC_SEQ_OP;
            cs_n_next = 1'b0;
          end
          else if (cmd_valid_i)
          begin
            done_next = 1'b1;
            if (cmd_i == sflsc_pkg::SFLSC_CMD_GO_FAST && attached)
            begin
              done_next = 1'b0;
              job_next = SFLSC_JOB_CHECK;
              addr_next = sflsc_pkg::SFLSC_IMG_ADDR;
              seq_next = SFLSC_SEQ_OP;
              cs_n_next = 1'b0;
            end
            else if (cmd_i == sflsc_pkg::SFLSC_CMD_RECONNECT
                     && st_reg == sflsc_pkg::SFLSC_ST_DETACHED)
            begin
              done_next = 1'b0;
              job_next = SFLSC_JOB_PROBE;
              seq_next = SFLSC_SEQ_OP;
              cs_n_next = 1'b0;
            end
            else if (st_reg == sflsc_pkg::SFLSC_ST_DETACHED)
            begin
              if (cmd_i == sflsc_pkg::SFLSC_CMD_RAW_DESELECT)
                cs_n_next = 1'b1;
              else if (cmd_i == sflsc_pkg::SFLSC_CMD_RAW_TRANSMIT
                       || cmd_i == sflsc_pkg::SFLSC_CMD_RAW_RECEIVE)
              begin
                done_next = 1'b0;
                cs_n_next = 1'b0;
                sh_start = 1'b1;
                sh_tx = raw_tx_byte_i;
                sh_rx = (cmd_i == sflsc_pkg::SFLSC_CMD_RAW_RECEIVE);
                seq_next = SFLSC_SEQ_RAW;
              end
            end
          end
          else if (fetch_req_i && st_reg == sflsc_pkg::SFLSC_ST_FULL)
          begin
            job_next = SFLSC_JOB_FETCH;
            addr_next = fetch_addr_i;
            seq_next = SFLSC_SEQ_OP;
            cs_n_next = 1'b0;
          end
        end
        SFLSC_SEQ_OP:
        begin
          sh_start = 1'b1;
          sh_tx = (job_reg == SFLSC_JOB_PROBE) ? sflsc_pkg::SFLSC_OP_READ_ID
                                               : sflsc_pkg::SFLSC_OP_QUAD_READ;
          bcnt_next = sflsc_pkg::SFLSC_ADDR_BYTES;
          seq_next = (job_reg == SFLSC_JOB_PROBE) ? SFLSC_SEQ_DATA
                                                  : SFLSC_SEQ_ADDR;
        end
        SFLSC_SEQ_ADDR:
        begin
          if (!sh_busy)
          begin
            sh_start = 1'b1;
            sh_quad = 1'b1;
            sh_tx = addr_reg[23:16];
            addr_next = {addr_reg[15:0], addr_reg[23:16]};
            bcnt_next = bcnt_reg - 3'h1;
            if (bcnt_reg == 3'h1)
            begin
              bcnt_next = sflsc_pkg::SFLSC_DUMMY_BYTES;
              seq_next = SFLSC_SEQ_DUMMY;
            end
          end
        end
        SFLSC_SEQ_DUMMY:
        begin
          if (!sh_busy)
          begin
            sh_start = 1'b1;
            sh_quad = 1'b1;
            sh_rx = 1'b1;
            bcnt_next = bcnt_reg - 3'h1;
            if (bcnt_reg == 3'h1)
              seq_next = SFLSC_SEQ_DATA;
          end
        end
        SFLSC_SEQ_DATA:
        begin
          if (!sh_busy && !sh_done)
          begin
            sh_start = 1'b1;
            sh_rx = 1'b1;
            sh_quad = (job_reg != SFLSC_JOB_PROBE);
            seq_next = SFLSC_SEQ_END;
          end
        end
        SFLSC_SEQ_RAW:
        begin
          if (sh_done)
          begin
            rawrx_next = sh_rxb;
            done_next = 1'b1;
            seq_next = SFLSC_SEQ_IDLE;
          end
        end
        SFLSC_SEQ_END:
        begin
          if (sh_done)
          begin
            seq_next = SFLSC_SEQ_IDLE;
            cs_n_next = 1'b1;
            unique case (job_reg)
              SFLSC_JOB_PROBE:
              begin
                done_next = (st_reg != sflsc_pkg::SFLSC_ST_INIT);
                if (sh_rxb != sflsc_pkg::SFLSC_ID_ABSENT
                    && sh_rxb != sflsc_pkg::SFLSC_ID_ZERO)
                  st_next = sflsc_pkg::SFLSC_ST_SLOW;
                else
                  st_next = sflsc_pkg::SFLSC_ST_DETACHED;
              end
              SFLSC_JOB_CHECK:
              begin
                done_next = 1'b1;
                fail_next = (sh_rxb != sflsc_pkg::SFLSC_IMG_SIGN);
                if (sh_rxb == sflsc_pkg::SFLSC_IMG_SIGN)
                  st_next = sflsc_pkg::SFLSC_ST_FULL;
              end
              default:
              begin
                fval_next = 1'b1;
                fdat_next = sh_rxb;
              end
            endcase
          end
        end
        default:
          seq_next = SFLSC_SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_reg <= sflsc_pkg::SFLSC_ST_INIT;
      seq_reg <= SFLSC_SEQ_IDLE;
      job_reg <= SFLSC_JOB_PROBE;
      addr_reg <= 24'h000000;
      bcnt_reg <= 3'h0;
      cs_n_reg <= 1'b1;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      fval_reg <= 1'b0;
      fdat_reg <= 8'h00;
      rawrx_reg <= 8'h00;
      boot_reg <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
      seq_reg <= seq_next;
      job_reg <= job_next;
      addr_reg <= addr_next;
      bcnt_reg <= bcnt_next;
      cs_n_reg <= cs_n_next;
      done_reg <= done_next;
      fail_reg <= fail_next;
      fval_reg <= fval_next;
      fdat_reg <= fdat_next;
      rawrx_reg <= rawrx_next;
      boot_reg <= boot_next;
    end
  end

  // ==========================================================
  // outputs
  assign link_state_o = st_reg;
  assign cmd_done_o = done_reg;
  assign fast_failed_o = fail_reg;
  assign raw_rx_byte_o = rawrx_reg;
  assign fetch_valid_o = fval_reg;
  assign fetch_data_o = fdat_reg;
  assign fetch_ready_o = (seq_reg == SFLSC_SEQ_IDLE) && !cmd_valid_i
                         && (st_reg == sflsc_pkg::SFLSC_ST_FULL);
  // idle bus: clock low, select high except after a raw transfer until raw deselect, disconnect or reconnect, data lines released
  assign flash_sclk_o = sh_sclk;
  assign flash_cs_n_o = cs_n_reg;
  assign flash_io_o = sh_io;
  assign flash_io_oe_o = sh_oe;
endmodule

// [verif/sflsc_monitor.sv]
// concurrent checks on the link controller ports
`timescale 1ns/1ns
module sflsc_monitor
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] cmd_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_done_o,
  input wire logic [3:0] link_state_o,
  input wire logic fast_failed_o,
  input wire logic fetch_ready_o,
  input wire logic fetch_valid_o,
  input wire logic flash_sclk_o,
  input wire logic flash_cs_n_o,
  input wire logic [3:0] flash_io_oe_o
);
  // ====================
  // assertions
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_state_onehot: assert property ($onehot(link_state_o))
    else $error("link state not one-hot");
  a_init_at_release: assert property ($rose(rst_n_i) |->
    link_state_o == sflsc_pkg::SFLSC_ST_INIT)
    else $error("not in init after reset");
  a_probe_exit: assert property
    ((link_state_o == sflsc_pkg::SFLSC_ST_INIT) ##1
    (link_state_o != sflsc_pkg::SFLSC_ST_INIT) |-> link_state_o inside
    {sflsc_pkg::SFLSC_ST_SLOW, sflsc_pkg::SFLSC_ST_DETACHED})
    else $error("probe ended in wrong state");
  a_full_from_slow: assert property
    ($rose(link_state_o == sflsc_pkg::SFLSC_ST_FULL) |->
    $past(link_state_o) == sflsc_pkg::SFLSC_ST_SLOW)
    else $error("full speed not reached from slow link");
  a_fail_not_full: assert property (fast_failed_o |->
    link_state_o != sflsc_pkg::SFLSC_ST_FULL)
    else $error("full speed despite failed image check");
  a_disc_detach: assert property (cmd_valid_i &&
    cmd_i == sflsc_pkg::SFLSC_CMD_DISCONNECT |-> ##[1:4]
    (link_state_o == sflsc_pkg::SFLSC_ST_DETACHED && flash_cs_n_o))
    else $error("disconnect did not detach");
  a_disc_done: assert property (cmd_valid_i &&
    cmd_i == sflsc_pkg::SFLSC_CMD_DISCONNECT |-> ##[1:2] cmd_done_o)
    else $error("disconnect not acknowledged");
  a_raw_ignored: assert property (cmd_valid_i &&
    cmd_i >= sflsc_pkg::SFLSC_CMD_RAW_DESELECT &&
    link_state_o inside {sflsc_pkg::SFLSC_ST_SLOW,
    sflsc_pkg::SFLSC_ST_FULL} |-> ##1 (cmd_done_o && $stable(link_state_o)))
    else $error("raw command outside detached not ignored");
  a_fetch_full: assert property
    ((fetch_ready_o || fetch_valid_o) |->
    link_state_o == sflsc_pkg::SFLSC_ST_FULL)
    else $error("fetch served outside full speed");
  a_idle_quiet: assert property
    (link_state_o == sflsc_pkg::SFLSC_ST_DETACHED && flash_cs_n_o |->
    !flash_sclk_o && flash_io_oe_o == 4'h0)
    else $error("bus active while detached and deselected");
  c_full: cover property (link_state_o == sflsc_pkg::SFLSC_ST_FULL);
  c_fetch: cover property (fetch_valid_o);
  c_failed: cover property (fast_failed_o);
endmodule

// [verif/sflsc_flash_model.sv]
// behavioural serial flash: id probe, quad read, raw answer
`timescale 1ns/1ns
module sflsc_flash_model
(
  input wire logic mclk_i,
  input wire logic present_i,
  input wire logic image_ok_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [7:0] op_o
);
  localparam logic [7:0] ID_BYTE = 8'h3C; // arbitrary value
  localparam logic [7:0] RAW_ANS = 8'h96;
  int cnt = 0;
  logic [23:0] addr = 24'h000000;
  logic [7:0] dat;
  initial io_o = 4'h0;
  initial op_o = 8'h00;
  // ====================
  // sampling on rising serial clock, msb first
  always @(posedge sclk_i or posedge cs_n_i)
    if (cs_n_i)
      cnt <= 0;
    else
    begin
      if (cnt < 8)
        op_o <= {op_o[6:0], io_i[0]};
      else if (cnt < 14)
        addr <= {addr[19:0], io_i};
      cnt <= cnt + 1;
    end
  // ====================
  // output changes on falling serial clock; idle lines toggle
  always @(posedge mclk_i)
  begin
    dat = (addr + 24'((cnt - 20) / 2) == 24'h000000) ?
      (image_ok_i ? sflsc_pkg::SFLSC_IMG_SIGN : 8'h00) :
      (addr[7:0] + 8'((cnt - 20) / 2)) ^ 8'h5A;
    if (!present_i)
      io_o <= 4'hF;
    else if (!cs_n_i && op_o == 8'h9F && cnt >= 8 && cnt < 16)
      io_o <= {~io_o[3:2], ID_BYTE[15 - cnt], ~io_o[0]};
    else if (!cs_n_i && op_o == 8'hEB && cnt >= 20)
      io_o <= cnt[0] ? dat[3:0] : dat[7:4];
    else if (!cs_n_i && op_o != 8'h9F && op_o != 8'hEB && cnt >= 8)
      io_o <= {~io_o[3:2], RAW_ANS[7 - (cnt - 8) % 8], ~io_o[0]};
    else
      io_o <= ~io_o;
  end
endmodule

// [verif/sflsc_tb.sv]
// self-checking bench of the flash link controller
`timescale 1ns/1ns
module testbench;
  typedef struct packed {logic [2:0] cmd; logic [3:0] st;} sflsc_row_s;
  logic mclk, rst_n, cmd_valid, cmd_done, fast_failed, fetch_req;
  logic fetch_ready, fetch_valid, sclk, cs_n, present, image_ok;
  logic [2:0] cmd;
  logic [7:0] tx_byte, raw_rx, fetch_data, op;
  logic [3:0] state, io_o, io_oe, io_i, flash_io;
  logic [23:0] fetch_addr;
  int n_errors = 0;
  int samples_checked = 0;
  sflsc_row_s rows [8] = '{
    '{sflsc_pkg::SFLSC_CMD_RAW_DESELECT, sflsc_pkg::SFLSC_ST_SLOW},
    '{sflsc_pkg::SFLSC_CMD_GO_FAST, sflsc_pkg::SFLSC_ST_FULL},
    '{sflsc_pkg::SFLSC_CMD_GO_FAST, sflsc_pkg::SFLSC_ST_FULL},
    '{sflsc_pkg::SFLSC_CMD_RECONNECT, sflsc_pkg::SFLSC_ST_FULL},
    '{sflsc_pkg::SFLSC_CMD_DISCONNECT, sflsc_pkg::SFLSC_ST_DETACHED},
    '{sflsc_pkg::SFLSC_CMD_GO_FAST, sflsc_pkg::SFLSC_ST_DETACHED},
    '{sflsc_pkg::SFLSC_CMD_RECONNECT, sflsc_pkg::SFLSC_ST_SLOW},
    '{sflsc_pkg::SFLSC_CMD_RAW_RECEIVE, sflsc_pkg::SFLSC_ST_SLOW}};
  assign io_i = (io_oe & io_o) | (~io_oe & flash_io);
  always #2 mclk = ~mclk;
  sflsc_link_ctrl i_dut
  (
    .mclk_i(mclk), .rst_n_i(rst_n), .cmd_i(cmd), .cmd_valid_i(cmd_valid),
    .raw_tx_byte_i(tx_byte), .cmd_done_o(cmd_done), .raw_rx_byte_o(raw_rx),
    .link_state_o(state), .fast_failed_o(fast_failed),
    .fetch_req_i(fetch_req), .fetch_addr_i(fetch_addr),
    .fetch_ready_o(fetch_ready), .fetch_valid_o(fetch_valid),
    .fetch_data_o(fetch_data), .flash_sclk_o(sclk), .flash_cs_n_o(cs_n),
    .flash_io_o(io_o), .flash_io_oe_o(io_oe), .flash_io_i(io_i)
  );
  sflsc_flash_model i_flash
  (
    .mclk_i(mclk), .present_i(present), .image_ok_i(image_ok),
    .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io_i), .io_o(flash_io), .op_o(op)
  );
  // ====================
  // compare, report and stimulus tasks
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic do_reset();
    int n;
    n = 0;
    rst_n = 1'b0;
    repeat (5) @(posedge mclk);
    chk_val({3'h0, cs_n, state}, 8'h11);
    #1;
    rst_n = 1'b1;
    while (state === sflsc_pkg::SFLSC_ST_INIT && n < 400)
    begin
      tick();
      n++;
    end
  endtask
  task automatic do_cmd(input logic [2:0] c, input logic [7:0] b,
    input bit w);
    int n;
    n = 0;
    tick();
    cmd = c;
    tx_byte = b;
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
    while (w && cmd_done !== 1'b1 && n < 400)
    begin
      tick();
      n++;
    end
    if (w)
      chk_val({7'h00, cmd_done}, 8'h01);
  endtask
  task automatic do_fetch(input logic [23:0] a, input logic [7:0] exp);
    int n;
    n = 0;
    fetch_addr = a;
    fetch_req = 1'b1;
    while (fetch_ready !== 1'b1 && n < 50)
    begin
      tick();
      n++;
    end
    tick();
    fetch_req = 1'b0;
    while (fetch_valid !== 1'b1 && n < 200)
    begin
      tick();
      n++;
    end
    chk_val({7'h00, fetch_valid}, 8'h01);
    chk_val(fetch_data, exp);
  endtask
  // ====================
  // main sequence
  initial
  begin
    mclk = 1'b0;
    rst_n = 1'b0;
    cmd = sflsc_pkg::SFLSC_CMD_NONE;
    cmd_valid = 1'b0;
    tx_byte = 8'h00;
    fetch_req = 1'b0;
    fetch_addr = 24'h000000;
    present = 1'b1;
    image_ok = 1'b1;
    do_reset();
    chk_val({4'h0, state}, 8'h04);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      do_cmd(rows[i].cmd, 8'h00, 1'b1);
      chk_val({4'h0, state}, {4'h0, rows[i].st});
    end
    $display("test table done");
    chk_val({7'h00, fetch_ready}, 8'h00);
    do_cmd(sflsc_pkg::SFLSC_CMD_GO_FAST, 8'h00, 1'b1);
    do_fetch(24'h000000, sflsc_pkg::SFLSC_IMG_SIGN);
    do_fetch(24'h000123, 8'h79);
    $display("test fetch done");
    do_cmd(sflsc_pkg::SFLSC_CMD_DISCONNECT, 8'h00, 1'b1);
    do_cmd(sflsc_pkg::SFLSC_CMD_RECONNECT, 8'h00, 1'b1);
    do_cmd(sflsc_pkg::SFLSC_CMD_GO_FAST, 8'h00, 1'b0);
    do_cmd(sflsc_pkg::SFLSC_CMD_DISCONNECT, 8'h00, 1'b1);
    chk_val({3'h0, cs_n, state}, 8'h12);
    #2;
    chk_val({7'h00, sclk}, 8'h00);
    $display("test abort done");
    do_cmd(sflsc_pkg::SFLSC_CMD_RAW_TRANSMIT, 8'h3B, 1'b1);
    chk_val(op, 8'h3B);
    do_cmd(sflsc_pkg::SFLSC_CMD_RAW_RECEIVE, 8'h00, 1'b1);
    chk_val(raw_rx, 8'h96);
    do_cmd(sflsc_pkg::SFLSC_CMD_RAW_DESELECT, 8'h00, 1'b1);
    chk_val({7'h00, cs_n}, 8'h01);
    $display("test raw done");
    image_ok = 1'b0;
    do_cmd(sflsc_pkg::SFLSC_CMD_RECONNECT, 8'h00, 1'b1);
    do_cmd(sflsc_pkg::SFLSC_CMD_GO_FAST, 8'h00, 1'b1);
    chk_val({3'h0, fast_failed, state}, 8'h14);
    $display("test image done");
    present = 1'b0;
    do_reset();
    chk_val({4'h0, state}, 8'h02);
    repeat (40)
    begin
      tick();
      #2;
      chk_val({2'h0, cs_n, sclk, io_oe}, 8'h20);
    end
    $display("test absent done");
    give_verdict();
  end
  initial
  begin
    #200000;
    n_errors++;
    give_verdict();
  end
endmodule
bind sflsc_link_ctrl sflsc_monitor i_mon
(
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i),
  .cmd_valid_i(cmd_valid_i), .cmd_done_o(cmd_done_o),
  .link_state_o(link_state_o), .fast_failed_o(fast_failed_o),
  .fetch_ready_o(fetch_ready_o), .fetch_valid_o(fetch_valid_o),
  .flash_sclk_o(flash_sclk_o), .flash_cs_n_o(flash_cs_n_o),
  .flash_io_oe_o(flash_io_oe_o)
);
